// [rtl/dtm_pkg.sv]
package dtm_pkg;
    // Timebase and conversion timing
    localparam int unsigned CLK_KHZ = 200000;
    localparam int unsigned T_FAST_MS = 125;
    localparam int unsigned T_BASIC_MS = 150;
    localparam int unsigned T_EXT_MS = 750;
    localparam int unsigned FAST_CYC = T_FAST_MS * CLK_KHZ;
    localparam int unsigned BASIC_CYC = T_BASIC_MS * CLK_KHZ;
    localparam int unsigned EXT_CYC = T_EXT_MS * CLK_KHZ;

    // Rate codes: 0 is 1/16 Hz, each step doubles, 7 is 8 Hz
    localparam logic [2:0] RATE_FASTEST = 3'h7;
    localparam logic [2:0] RATE_EXT_LIMIT = 3'h4;
    localparam logic [2:0] RATE_RST = 3'h2;

    // Slave address base; the nine addresses start at it
    localparam logic [6:0] ADDR_BASE = 7'h18;
    localparam logic [1:0] PIN_LOW = 2'h0;
    localparam logic [1:0] PIN_HIGH = 2'h1;

    // Register indices, byte address is four times the index
    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_RATE = 4'h1;
    localparam logic [3:0] IDX_ONESHOT = 4'h2;
    localparam logic [3:0] IDX_LOCAL = 4'h3;
    localparam logic [3:0] IDX_REM_INT = 4'h4;
    localparam logic [3:0] IDX_REM_FRAC = 4'h5;
    localparam logic [3:0] IDX_HI_LIM = 4'h6;
    localparam logic [3:0] IDX_LO_LIM = 4'h7;
    localparam logic [3:0] IDX_STATUS = 4'h8;
    localparam logic [3:0] IDX_IRQ_STAT = 4'h9;
    localparam logic [3:0] IDX_IRQ_CLR = 4'ha;
    localparam logic [3:0] IDX_IRQ_EN = 4'hb;

    // Field positions and reset values
    localparam int CTRL_STANDBY_PIN_N = 0;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_HI = 1;
    localparam int IRQ_LO = 2;
    localparam logic [7:0] HI_RST = 8'h7f;
    localparam logic [7:0] LO_RST = 8'h80;

    typedef struct packed {
        logic [7:0] loc;
        logic [7:0] rem_int;
        logic [2:0] rem_frac;
    } dtm_temp_type;

    typedef struct packed {
        logic [3:0] ptr;
        logic [7:0] data;
    } dtm_wreq_type;

    typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_CONV = 2'b10} dtm_state_type;
endpackage

// [rtl/dtm_smb_slave.sv]
`timescale 1ns/1ps
module dtm_smb_slave (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial pins, raw from the pads
    input wire logic scl_pin,
    input wire logic sda_pin,
    output logic sda_oe,
    // Register side
    input wire logic [6:0] dev_addr,
    input wire logic [7:0] rdata,
    output logic [3:0] ptr,
    output logic wr,
    output dtm_pkg::dtm_wreq_type wreq
);
    logic [1:0] scl_s_q, sda_s_q;
    logic scl_p_q, sda_p_q, act_q, rd_q, oe_q, wr_q;
    logic [3:0] cnt_q, ptr_q;
    logic [1:0] byte_q;
    logic [7:0] sh_q, tx_q, wd_q;
    logic start_w, stop_w, rise_w, fall_w;

    // Two-stage synchronisers; stage two and its one-cycle delayed copy feed the edge logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_pin};
            sda_s_q <= {sda_s_q[0], sda_pin};
            scl_p_q <= scl_s_q[1];
            sda_p_q <= sda_s_q[1];
        end
    end

    // Start and stop are data edges while the clock is high
    assign start_w = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
    assign stop_w = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];
    assign rise_w = scl_s_q[1] & ~scl_p_q;
    assign fall_w = ~scl_s_q[1] & scl_p_q;

    // Byte engine; data only changes while the clock is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            act_q <= 1'b0;
            rd_q <= 1'b0;
            oe_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 4'h0;
            byte_q <= 2'h0;
            ptr_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            wd_q <= 8'h00;
        end else begin
            wr_q <= 1'b0;
            if (start_w || stop_w) begin
                act_q <= start_w;
                rd_q <= 1'b0;
                oe_q <= 1'b0; // Pin released, never driven high
                cnt_q <= start_w ? 4'hf : 4'h0; // One below zero: the fall after a start is no bit
                byte_q <= 2'h0;
            end else if (act_q && rise_w) begin
                if (cnt_q < 4'h8 && !rd_q) begin
                    sh_q <= {sh_q[6:0], sda_s_q[1]};
                end else if (cnt_q == 4'h8 && rd_q && sda_s_q[1]) begin
                    act_q <= 1'b0; // Master nack ends the read
                end
            end else if (act_q && fall_w) begin
                if (cnt_q == 4'h7) begin
                    cnt_q <= 4'h8;
                    oe_q <= ~rd_q;
                    if (byte_q == 2'h0) begin
                        if (sh_q[7:1] == dev_addr) begin
                            rd_q <= sh_q[0];
                        end else begin
                            act_q <= 1'b0;
                            oe_q <= 1'b0;
                        end
                    end else if (!rd_q && byte_q == 2'h1) begin
                        ptr_q <= sh_q[3:0];
                    end else if (!rd_q) begin
                        wr_q <= 1'b1;
                        wd_q <= sh_q;
                    end
                end else if (cnt_q == 4'h8) begin
                    cnt_q <= 4'h0;
                    byte_q <= (byte_q == 2'h2) ? byte_q : byte_q + 2'h1;
                    oe_q <= rd_q & ~rdata[7];
                    tx_q <= {rdata[6:0], 1'b0};
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                    oe_q <= rd_q & ~tx_q[7];
                    tx_q <= {tx_q[6:0], 1'b0};
                end
            end
        end
    end

    assign sda_oe = oe_q;
    assign ptr = ptr_q;
    assign wr = wr_q;
    assign wreq = '{ptr: ptr_q, data: wd_q};
endmodule // dtm_smb_slave

// [rtl/dtm_ctrl.sv]
`timescale 1ns/1ps
// What this block does
// - Running conversions refresh both result registers
// - Conversions start periodically at programmed rate
// - One-shot request starts a conversion once none is in flight
// - Local result always in whole degrees
// - Remote: eighth degrees extended, whole degrees basic
// - Slow rates pick extended, fast rates basic
// - Over and under temperature both raise alarm
// - Host-programmed limits compared against measured temperatures
// - Two three-state pins select one of nine
// - Standby by host write or by pin
// - Pin high runs, pin low stands by
// - Alert output is open-drain only
// - Data line open-drain, clock line input only
// - Address pins sampled at reset and at conversion starts below the fastest rate
// - Low supply keeps results; reset gives zero
// - Conversion takes 150 ms basic, 750 ms extended
module dtm_ctrl #(
    parameter int unsigned FAST_CYC = dtm_pkg::FAST_CYC,
    parameter int unsigned BASIC_CYC = dtm_pkg::BASIC_CYC,
    parameter int unsigned EXT_CYC = dtm_pkg::EXT_CYC
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [5:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Serial bus pins
    input wire logic SCL_PIN,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    // Alert and interrupt
    output logic ALERT_O,
    output logic ALERT_OE,
    output logic IRQ,
    // Strap and standby pins, pad codes 0 low, 1 high, 2 open
    input wire logic STANDBY_PIN_N,
    input wire logic [1:0] ADDR_SEL_PIN_A,
    input wire logic [1:0] ADDR_SEL_PIN_B,
    // Analog front end
    input wire logic ADC_OK,
    input wire logic [7:0] LOCAL_TEMP,
    input wire logic [10:0] REMOTE_TEMP,
    output logic CONV_BUSY,
    output logic EXT_MODE
);
    localparam int SW = 25;
    logic [SW-1:0] s1_q, s2_q;
    logic standby_pin_n_pin_s, adc_ok_s;
    logic [1:0] pin_a_s, pin_b_s;
    logic [7:0] loc_s;
    logic [10:0] rem_s;
    dtm_pkg::dtm_state_type st_q;
    dtm_pkg::dtm_temp_type temp_q;
    dtm_pkg::dtm_wreq_type smb_req, pend_q;
    logic pend_q_v, smb_wr, pready_q, pslverr_q, irq_q, alert_q, od_low_q;
    logic [31:0] prdata_q, per_cnt_q, conv_cnt_q, per_load, conv_age_q;
    logic [7:0] ctrl_q, hi_q, lo_q, rd_val, smb_rdata;
    logic [2:0] rate_q, irq_stat_q, irq_en_q, ev_w, addr_init_q;
    logic [6:0] dev_addr_q;
    logic [3:0] smb_ptr, wr_idx, apb_idx;
    logic [7:0] wr_data;
    logic due_q, oneshot_q, ext_q, al_hi_q, al_lo_q, standby_pin_n, start_w, done_w;
    logic hi_w, lo_w, acc, apb_wr, wr_en, mapped, upd_w;

    // All pad and front-end inputs cross through two flops; the front
    // end holds its result words steady while a conversion is busy
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            s1_q <= {1'b1, {(SW - 1){1'b0}}}; // Standby pin at its run level, no false standby
            s2_q <= {1'b1, {(SW - 1){1'b0}}};
        end else begin
            s1_q <= {STANDBY_PIN_N, ADDR_SEL_PIN_A, ADDR_SEL_PIN_B, ADC_OK, LOCAL_TEMP, REMOTE_TEMP};
            s2_q <= s1_q;
        end
    end
    assign {standby_pin_n_pin_s, pin_a_s, pin_b_s, adc_ok_s, loc_s, rem_s} = s2_q;

    // Three-state pad code to digit: low 0, open 1, high 2
    function automatic logic [3:0] tri_val(input logic [1:0] p);
        if (p == dtm_pkg::PIN_LOW) begin
            tri_val = 4'h0;
        end else if (p == dtm_pkg::PIN_HIGH) begin
            tri_val = 4'h2;
        end else begin
            tri_val = 4'h1;
        end
    endfunction

    // Register read mux shared by APB and the serial bus
    function automatic logic [7:0] rd_mux(input logic [3:0] i);
        if (i == dtm_pkg::IDX_CTRL) begin
            rd_mux = ctrl_q;
        end else if (i == dtm_pkg::IDX_RATE) begin
            rd_mux = {5'h00, rate_q};
        end else if (i == dtm_pkg::IDX_LOCAL) begin
            rd_mux = temp_q.loc;
        end else if (i == dtm_pkg::IDX_REM_INT) begin
            rd_mux = temp_q.rem_int;
        end else if (i == dtm_pkg::IDX_REM_FRAC) begin
            rd_mux = {temp_q.rem_frac, 5'h00};
        end else if (i == dtm_pkg::IDX_HI_LIM) begin
            rd_mux = hi_q;
        end else if (i == dtm_pkg::IDX_LO_LIM) begin
            rd_mux = lo_q;
        end else if (i == dtm_pkg::IDX_STATUS) begin
            rd_mux = {3'h0, al_lo_q, al_hi_q, ext_q, standby_pin_n, st_q == dtm_pkg::ST_CONV};
        end else if (i == dtm_pkg::IDX_IRQ_STAT) begin
            rd_mux = {5'h00, irq_stat_q};
        end else if (i == dtm_pkg::IDX_IRQ_EN) begin
            rd_mux = {5'h00, irq_en_q};
        end else begin
            rd_mux = 8'h00;
        end
    endfunction
    dtm_smb_slave u_smb (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .scl_pin(SCL_PIN),
        .sda_pin(SDA_I),
        .sda_oe(SDA_OE),
        .dev_addr(dev_addr_q),
        .rdata(smb_rdata),
        .ptr(smb_ptr),
        .wr(smb_wr),
        .wreq(smb_req)
    );
    // Read mux in a process: it follows register changes, not only a new index
    always_comb begin
        smb_rdata = rd_mux(smb_ptr);
        rd_val = rd_mux(apb_idx);
    end

    // APB decode; one wait state, pready registered
    assign apb_idx = PADDR[5:2];
    assign acc = PSEL & PENABLE;
    assign mapped = apb_idx <= dtm_pkg::IDX_IRQ_EN;
    assign apb_wr = acc & pready_q & PWRITE & mapped;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= acc & ~pready_q;
            pslverr_q <= acc & ~pready_q & ~mapped;
            prdata_q <= (acc && !pready_q && !PWRITE) ? {24'h0, rd_val} : 32'h0;
        end
    end

    // Serial writes wait one slot when APB writes in the same cycle
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pend_q_v <= 1'b0;
            pend_q <= '0;
        end else if (smb_wr) begin
            pend_q_v <= 1'b1;
            pend_q <= smb_req;
        end else if (!apb_wr) begin
            pend_q_v <= 1'b0;
        end
    end
    assign wr_en = apb_wr | pend_q_v;
    assign wr_idx = apb_wr ? apb_idx : pend_q.ptr;
    assign wr_data = apb_wr ? PWDATA[7:0] : pend_q.data;

    // Host-written settings: standby, rate, limits, interrupt enables
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= 8'h00;
            rate_q <= dtm_pkg::RATE_RST;
            hi_q <= dtm_pkg::HI_RST;
            lo_q <= dtm_pkg::LO_RST;
            irq_en_q <= 3'h0;
        end else if (wr_en) begin
            if (wr_idx == dtm_pkg::IDX_CTRL) begin
                ctrl_q <= wr_data;
            end else if (wr_idx == dtm_pkg::IDX_RATE) begin
                rate_q <= wr_data[2:0];
            end else if (wr_idx == dtm_pkg::IDX_HI_LIM) begin
                hi_q <= wr_data;
            end else if (wr_idx == dtm_pkg::IDX_LO_LIM) begin
                lo_q <= wr_data;
            end else if (wr_idx == dtm_pkg::IDX_IRQ_EN) begin
                irq_en_q <= wr_data[2:0];
            end
        end
    end

    // Either source puts the part in standby; bus logic keeps running
    assign standby_pin_n = ctrl_q[dtm_pkg::CTRL_STANDBY_PIN_N] | ~standby_pin_n_pin_s;
    // Period timer reloads from the rate code; shorter codes mean longer periods
    assign per_load = 32'(FAST_CYC) << (dtm_pkg::RATE_FASTEST - rate_q);
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            per_cnt_q <= 32'h0;
            due_q <= 1'b0;
        end else if (standby_pin_n) begin
            per_cnt_q <= per_load;
            due_q <= 1'b0;
        end else begin
            per_cnt_q <= (per_cnt_q == 32'h0) ? per_load - 32'h1 : per_cnt_q - 32'h1;
            if (per_cnt_q == 32'h0) begin
                due_q <= 1'b1;
            end else if (start_w) begin
                due_q <= 1'b0;
            end
        end
    end

    // One-shot waits only for a conversion already in flight
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            oneshot_q <= 1'b0;
        end else if (wr_en && wr_idx == dtm_pkg::IDX_ONESHOT) begin
            oneshot_q <= 1'b1;
        end else if (start_w) begin
            oneshot_q <= 1'b0;
        end
    end

    assign start_w = (st_q == dtm_pkg::ST_IDLE) & ((due_q & ~standby_pin_n) | oneshot_q);
    assign done_w = (st_q == dtm_pkg::ST_CONV) & (conv_cnt_q == 32'h0);

    // Conversion sequencer; busy time depends on the mode
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= dtm_pkg::ST_IDLE;
            conv_cnt_q <= 32'h0;
            ext_q <= 1'b0;
        end else begin
            case (st_q)
                dtm_pkg::ST_IDLE: begin
                    if (start_w) begin
                        st_q <= dtm_pkg::ST_CONV;
                        ext_q <= rate_q < dtm_pkg::RATE_EXT_LIMIT;
                        conv_cnt_q <= (rate_q < dtm_pkg::RATE_EXT_LIMIT) ?
                            32'(EXT_CYC - 1) : 32'(BASIC_CYC - 1);
                    end
                end
                dtm_pkg::ST_CONV: begin
                    if (done_w) begin
                        st_q <= dtm_pkg::ST_IDLE;
                    end else begin
                        conv_cnt_q <= conv_cnt_q - 32'h1;
                    end
                end
                default: st_q <= dtm_pkg::ST_IDLE;
            endcase
        end
    end

    // Strap pins caught after reset release and at slower conversion starts
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            addr_init_q <= 3'h0;
            dev_addr_q <= dtm_pkg::ADDR_BASE;
        end else if (!(&addr_init_q) || (start_w && rate_q != dtm_pkg::RATE_FASTEST)) begin
            addr_init_q <= {addr_init_q[1:0], 1'b1}; // Three edges: pins clear the synchroniser first
            dev_addr_q <= dtm_pkg::ADDR_BASE +
                {3'h0, (tri_val(pin_a_s) << 1) + tri_val(pin_a_s) + tri_val(pin_b_s)};
        end
    end

    // Signed compare of both channels against the limits
    assign hi_w = ($signed(loc_s) > $signed(hi_q)) | ($signed(rem_s[10:3]) > $signed(hi_q));
    assign lo_w = ($signed(loc_s) < $signed(lo_q)) | ($signed(rem_s[10:3]) < $signed(lo_q));
    assign upd_w = done_w & adc_ok_s;

    // Results refresh only with a healthy supply, else old values stay
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            temp_q <= '0;
            al_hi_q <= 1'b0;
            al_lo_q <= 1'b0;
        end else if (upd_w) begin
            temp_q.loc <= loc_s;
            temp_q.rem_int <= rem_s[10:3];
            temp_q.rem_frac <= ext_q ? rem_s[2:0] : 3'h0;
            al_hi_q <= hi_w;
            al_lo_q <= lo_w;
        end
    end

    // Sticky events; a new event beats a clear in the same cycle
    assign ev_w = {upd_w & lo_w, upd_w & hi_w, done_w};
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            irq_stat_q <= 3'h0;
        end else if (wr_en && wr_idx == dtm_pkg::IDX_IRQ_CLR) begin
            irq_stat_q <= (irq_stat_q & ~wr_data[2:0]) | ev_w;
        end else begin
            irq_stat_q <= irq_stat_q | ev_w;
        end
    end

    // Output flops; the alert pin only ever pulls low
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            irq_q <= 1'b0;
            alert_q <= 1'b0;
            od_low_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_en_q);
            alert_q <= al_hi_q | al_lo_q;
            od_low_q <= 1'b0;
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign SDA_O = od_low_q;
    assign ALERT_O = od_low_q;
    assign ALERT_OE = alert_q;
    assign IRQ = irq_q;
    assign CONV_BUSY = st_q == dtm_pkg::ST_CONV;
    assign EXT_MODE = ext_q;

    // Helper: age of the running conversion
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            conv_age_q <= 32'h0;
        end else begin
            conv_age_q <= (st_q == dtm_pkg::ST_CONV) ? conv_age_q + 32'h1 : 32'h0;
        end
    end

    default clocking dc @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    a_result_refresh: assert property (upd_w |=> temp_q.rem_int == $past(rem_s[10:3]))
        else $error("remote result not refreshed");
    a_period_start: assert property (st_q == dtm_pkg::ST_IDLE && due_q && !standby_pin_n |=> CONV_BUSY)
        else $error("periodic start missed");
    a_oneshot_go: assert property (wr_en && wr_idx == dtm_pkg::IDX_ONESHOT && !CONV_BUSY |-> ##2 CONV_BUSY)
        else $error("one-shot did not start");
    a_local_hold: assert property ($changed(temp_q.loc) |-> $past(upd_w))
        else $error("local result changed outside completion");
    a_basic_frac: assert property (upd_w && !ext_q |=> temp_q.rem_frac == 3'h0)
        else $error("basic mode fraction not zero");
    a_mode_select: assert property (start_w |=> ext_q == ($past(rate_q) < dtm_pkg::RATE_EXT_LIMIT))
        else $error("wrong mode for rate");
    a_alarm_pin: assert property (upd_w && (hi_w || lo_w) |-> ##2 ALERT_OE)
        else $error("alarm not on alert pin");
    a_limit_cmp: assert property (upd_w && $signed(loc_s) < $signed(lo_q) |=> al_lo_q)
        else $error("low limit not flagged");
    a_standby_idle: assert property (standby_pin_n && !oneshot_q && !CONV_BUSY |=> !CONV_BUSY)
        else $error("periodic start in standby");
    a_addr_fast: assert property (start_w && rate_q == dtm_pkg::RATE_FASTEST |=> $stable(dev_addr_q))
        else $error("address resampled at fastest rate");
    a_uvlo_keep: assert property (done_w && !adc_ok_s |=> $stable(temp_q))
        else $error("results changed with low supply");
    a_conv_time: assert property (conv_age_q <= 32'(EXT_CYC))
        else $error("conversion overran");
    c_ext_done: cover property (upd_w && ext_q);
    c_basic_done: cover property (upd_w && !ext_q);
    c_irq: cover property (IRQ && ALERT_OE);
endmodule // dtm_ctrl

// [verif/dtm_smb_host.sv]
`timescale 1ns/1ps
// Serial host model: clock idles high, data is only pulled low or released
module dtm_smb_host (
    // Clock and serial wire
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    // Idle bus: both lines released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Quarter bit of 8 cycles keeps each clock phase far above 4 cycles
    task automatic q;
        repeat (8) @(posedge clk);
    endtask
    // Data moves mid-low so it never looks like a start or stop
    task automatic bit_io(input logic b, output logic r);
        q();
        sda_pull <= ~b;
        q();
        scl <= 1'b1;
        q();
        r = sda_line;
        q();
        scl <= 1'b0;
    endtask
    // Start, address and write bit, pointer, one data byte, stop
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic [2:0] ack);
        logic [26:0] s;
        logic r;
        s = {a, 1'b0, 1'b1, p, 1'b1, d, 1'b1};
        sda_pull <= 1'b1;
        q();
        scl <= 1'b0;
        for (int i = 26; i >= 0; i--) begin
            bit_io(s[i], r);
            if (i % 9 == 0) ack[i / 9] = ~r;
        end
        q();
        sda_pull <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda_pull <= 1'b0;
        q();
    endtask
endmodule // dtm_smb_host

// [verif/dual_temp_monitor_ctrl_tb.sv]
`timescale 1ns/1ps
module dual_temp_monitor_ctrl_tb;
    typedef struct packed {logic w; logic [3:0] i; logic [7:0] d; logic [7:0] x; logic e;} dtm_row_type;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, standby_pin_n_n = 1, adc_ok = 1;
    logic [5:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rv;
    logic pready, pslverr, sda_oe, sda_o, alert_o, alert_oe, irq, busy, ext, scl, pull, ev;
    logic [1:0] pin_a = 2'h1, pin_b = 2'h2;
    logic [7:0] loc = 8'h19;
    logic [10:0] rem = 11'h155;
    logic [2:0] ack;
    int miscompares = 0, n_checks = 0, cnt, rise, a;
    wire sda = ~(pull | (sda_oe & ~sda_o));
    // Reset values, read-only and unmapped places
    dtm_row_type rows [10] = '{'{0, 1, 0, 2, 0}, '{0, 6, 0, 8'h7f, 0}, '{0, 7, 0, 8'h80, 0}, '{0, 3, 0, 0, 0},
        '{0, 4, 0, 0, 0}, '{1, 12, 8'h5a, 0, 1}, '{0, 12, 0, 0, 1}, '{1, 11, 7, 0, 0}, '{1, 9, 8'hff, 0, 0},
        '{0, 9, 0, 0, 0}};
    dtm_ctrl #(.FAST_CYC(200), .BASIC_CYC(60), .EXT_CYC(300)) u_dut (.CLK_SYS(clk), .RST_N(rst_n),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SCL_PIN(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
        .ALERT_O(alert_o), .ALERT_OE(alert_oe), .IRQ(irq), .STANDBY_PIN_N(standby_pin_n_n), .ADDR_SEL_PIN_A(pin_a),
        .ADDR_SEL_PIN_B(pin_b), .ADC_OK(adc_ok), .LOCAL_TEMP(loc), .REMOTE_TEMP(rem), .CONV_BUSY(busy),
        .EXT_MODE(ext));
    dtm_smb_host u_host (.clk(clk), .sda_line(sda), .scl(scl), .sda_pull(pull));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic stop_test;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // One transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [3:0] i, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {i, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        cnt = 0;
        do begin
            @(posedge clk);
            cnt++;
        end while (pready !== 1'b1 && cnt < 20);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (cnt >= 20) begin
            miscompares++;
            stop_test();
        end
    endtask
    // Bounded wait for the busy flag
    task automatic wt(input logic v);
        cnt = 0;
        while (busy !== v) begin
            @(posedge clk);
            cnt++;
            if (cnt > 2000) begin
                miscompares++;
                stop_test();
            end
        end
    endtask
    // One-shot conversion; leaves start delay in rise, length in cnt
    task automatic conv;
        apb(1, dtm_pkg::IDX_ONESHOT, 0);
        wt(1);
        rise = cnt;
        wt(0);
        repeat (3) @(posedge clk);
    endtask
    // Busy cycles seen over a stretch
    task automatic quiet;
        a = 0;
        repeat (600) @(posedge clk) a += (busy !== 1'b0);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[k]) begin
            apb(rows[k].w, rows[k].i, rows[k].d);
            chk(ev, rows[k].e);
            if (!rows[k].w) chk(rv, rows[k].x);
        end
        wt(0);
        apb(0, dtm_pkg::IDX_LOCAL, 0);
        chk(rv, 8'h19);
        apb(0, dtm_pkg::IDX_REM_INT, 0);
        chk(rv, 8'h2a);
        standby_pin_n_n <= 1'b0;
        wt(0);
        // Every rate code: mode, busy length, one-shot start
        for (int r = 0; r < 8; r++) begin
            apb(1, dtm_pkg::IDX_RATE, r[7:0]);
            conv();
            chk(rise <= 3, 1);
            chk(cnt, r < 4 ? 300 : 60);
            chk(ext, r < 4);
            apb(0, dtm_pkg::IDX_REM_FRAC, 0);
            chk(rv, r < 4 ? 8'ha0 : 8'h0);
            apb(0, dtm_pkg::IDX_LOCAL, 0);
            chk(rv, 8'h19);
        end
        quiet();
        chk(a, 0);
        standby_pin_n_n <= 1'b1;
        wt(1);
        wt(0);
        a = cnt;
        wt(1);
        chk(a + cnt, 200);
        apb(1, dtm_pkg::IDX_CTRL, 1);
        wt(0);
        quiet();
        chk(a, 0);
        standby_pin_n_n <= 1'b0;
        apb(1, dtm_pkg::IDX_CTRL, 0);
        apb(1, dtm_pkg::IDX_RATE, 2);
        // Over, then under, then clear of the alarm
        apb(1, dtm_pkg::IDX_HI_LIM, 8'h20);
        apb(1, dtm_pkg::IDX_IRQ_CLR, 7);
        conv();
        apb(0, dtm_pkg::IDX_IRQ_STAT, 0);
        chk(rv, 3);
        chk({alert_oe, alert_o, irq}, 3'b101);
        apb(1, dtm_pkg::IDX_IRQ_EN, 0);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        apb(1, dtm_pkg::IDX_HI_LIM, 8'h7f);
        apb(1, dtm_pkg::IDX_LO_LIM, 8'h30);
        apb(1, dtm_pkg::IDX_IRQ_CLR, 7);
        conv();
        apb(0, dtm_pkg::IDX_IRQ_STAT, 0);
        chk(rv, 5);
        apb(1, dtm_pkg::IDX_LO_LIM, 8'h80);
        conv();
        chk(alert_oe, 0);
        // Serial bus: strap high and open gives address 0x1f
        u_host.wr(7'h1e, dtm_pkg::IDX_HI_LIM, 8'h55, ack);
        chk(ack, 0);
        u_host.wr(7'h1f, dtm_pkg::IDX_HI_LIM, 8'h55, ack);
        chk(ack, 7);
        apb(0, dtm_pkg::IDX_HI_LIM, 0);
        chk(rv, 8'h55);
        pin_b <= 2'h0;
        conv();
        u_host.wr(7'h1e, dtm_pkg::IDX_HI_LIM, 8'h66, ack);
        chk(ack, 7);
        adc_ok <= 1'b0;
        loc <= 8'h05;
        apb(1, dtm_pkg::IDX_ONESHOT, 0);
        repeat (400) @(posedge clk);
        apb(0, dtm_pkg::IDX_LOCAL, 0);
        chk(rv, 8'h19);
        stop_test();
    end
endmodule // dual_temp_monitor_ctrl_tb
